// File: core/regfile_pkg.sv
package regfile_pkg;

  localparam int DATA_W = 16;
  localparam int WIDE_W = 32;
  localparam int BYTE_W = 8;
  localparam int VEC_W = 20;
  localparam int FLAG_W = 11;
  localparam int BANK_REGS = 7;
  localparam int BANKS = 2;
  localparam int SEL_W = 4;
  localparam int IDX_W = 3;

  // Register index; the byte address on the software port is index * 4
  typedef enum logic [3:0] {
    sel_data_0 = 4'h0,
    sel_data_1 = 4'h1,
    sel_data_2 = 4'h2,
    sel_data_3 = 4'h3,
    sel_address_0 = 4'h4,
    sel_address_1 = 4'h5,
    sel_frame_base = 4'h6,
    sel_static_base = 4'h7,
    sel_user_stack = 4'h8,
    sel_interrupt_stack = 4'h9,
    sel_vector_table = 4'ha,
    sel_program_counter = 4'hb,
    sel_flags = 4'hc,
    sel_active_stack = 4'hd
  } reg_sel_t;

  localparam int ADDR_SHIFT = 2;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;

  typedef enum logic [1:0] {
    size_low_byte = 2'h0,
    size_high_byte = 2'h1,
    size_word = 2'h2,
    size_pair = 2'h3
  } access_size_t;

  // Flag register layout
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DEBUG = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SIGN = 3;
  localparam int FLAG_BANK = 4;
  localparam int FLAG_OVERFLOW = 5;
  localparam int FLAG_IRQ_ENABLE = 6;
  localparam int FLAG_STACK_SEL = 7;
  localparam int IPL_LSB = 8;
  localparam int IPL_W = 3;

  localparam logic [FLAG_W-1:0] FLAGS_RESET = 11'h000;
  localparam logic [VEC_W-1:0] PC_RESET = 20'h00000;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_RESET = 20'h00000;

  localparam int SWI_NUM_W = 6;
  localparam logic [SWI_NUM_W-1:0] SWI_STACK_MAX = 6'h1f;

  typedef struct packed {
    logic en;
    reg_sel_t sel;
    access_size_t size;
    logic [WIDE_W-1:0] data;
  } exec_write_t;

  typedef struct packed {
    logic en;
    access_size_t size;
    logic [WIDE_W-1:0] result;
    logic carry;
    logic overflow;
  } alu_flags_t;

  typedef struct packed {
    logic req;
    logic [IPL_W-1:0] level;
  } irq_req_t;

endpackage

// File: core/regfile_bank.sv
`timescale 1ns/1ps
module regfile_bank #(
  parameter int REGS = 7,
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [REGS-1:0] we_lo,
  input wire logic [REGS-1:0] we_hi,
  input wire logic [REGS-1:0][W-1:0] wdata,
  output logic [REGS-1:0][W-1:0] q
);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < REGS; i++) begin
        if (we_lo[i]) begin
          q[i][W/2-1:0] <= wdata[i][W/2-1:0];
        end
        if (we_hi[i]) begin
          q[i][W-1:W/2] <= wdata[i][W-1:W/2];
        end
      end
    end
  end

endmodule

// File: core/cpu_register_file_flags.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module cpu_register_file_flags #(
  parameter int ADDR_W = 6
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] sw_addr,
  input wire logic [regfile_pkg::WIDE_W-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [regfile_pkg::WIDE_W-1:0] sw_rdata_q,
  input wire regfile_pkg::exec_write_t exec_wr,
  input wire regfile_pkg::reg_sel_t exec_rsel,
  input wire regfile_pkg::access_size_t exec_rsize,
  output logic [regfile_pkg::WIDE_W-1:0] exec_rdata_q,
  input wire regfile_pkg::alu_flags_t alu,
  input wire logic pc_load,
  input wire logic [regfile_pkg::VEC_W-1:0] pc_value,
  input wire regfile_pkg::irq_req_t irq,
  input wire logic int_ack,
  input wire logic swi_exec,
  input wire logic [regfile_pkg::SWI_NUM_W-1:0] swi_num,
  output logic irq_take_q,
  output logic [regfile_pkg::VEC_W-1:0] program_counter_q,
  output logic [regfile_pkg::FLAG_W-1:0] processor_flags_q
);

  localparam int NB = regfile_pkg::BANK_REGS;
  localparam int DW = regfile_pkg::DATA_W;
  localparam int WW = regfile_pkg::WIDE_W;
  localparam int BW = regfile_pkg::BYTE_W;
  localparam int VW = regfile_pkg::VEC_W;

  typedef logic [NB-1:0][DW-1:0] bank_t;

  bank_t bank_q [regfile_pkg::BANKS];
  bank_t bank_wd;
  logic [NB-1:0] bank_we_lo;
  logic [NB-1:0] bank_we_hi;
  logic [DW-1:0] static_base_q;
  logic [DW-1:0] user_stack_pointer_q;
  logic [DW-1:0] interrupt_stack_pointer_q;
  logic [VW-1:0] vector_table_base_q;

  logic bank_sel;
  logic stack_sel;
  assign bank_sel = processor_flags_q[regfile_pkg::FLAG_BANK];
  assign stack_sel = processor_flags_q[regfile_pkg::FLAG_STACK_SEL];

  // Software port decode
  regfile_pkg::reg_sel_t sw_sel;
  logic sw_hit;
  assign sw_sel = regfile_pkg::reg_sel_t'(
    sw_addr[regfile_pkg::ADDR_SHIFT +: regfile_pkg::SEL_W]);
  assign sw_hit = (sw_addr[regfile_pkg::ADDR_SHIFT-1:0] ==
                   regfile_pkg::ADDR_ALIGN) &&
                  (sw_sel <= regfile_pkg::sel_flags);

  // Execution writes take priority over the software port
  logic wr_en;
  regfile_pkg::reg_sel_t wr_sel;
  regfile_pkg::access_size_t wr_size;
  logic [WW-1:0] wr_data;

  always_comb begin
    if (exec_wr.en) begin
      wr_en = 1'b1;
      wr_sel = exec_wr.sel;
      wr_size = exec_wr.size;
      wr_data = exec_wr.data;
    end else begin
      wr_en = sw_wr && sw_hit &&
              (sw_sel != regfile_pkg::sel_program_counter);
      wr_sel = sw_sel;
      wr_size = regfile_pkg::size_word;
      wr_data = sw_wdata;
    end
  end

  localparam int IDX_WD = regfile_pkg::IDX_W;

  function automatic logic [IDX_WD-1:0] partner_of(
    input logic [IDX_WD-1:0] idx);
    partner_of = (idx == IDX_WD'(regfile_pkg::sel_address_0)) ?
                 IDX_WD'(regfile_pkg::sel_address_1) : idx + IDX_WD'(2);
  endfunction

  function automatic logic pairable(input regfile_pkg::reg_sel_t s);
    pairable = (s == regfile_pkg::sel_data_0) ||
               (s == regfile_pkg::sel_data_1) ||
               (s == regfile_pkg::sel_address_0);
  endfunction

  function automatic logic byteable(input regfile_pkg::reg_sel_t s);
    byteable = (s == regfile_pkg::sel_data_0) ||
               (s == regfile_pkg::sel_data_1);
  endfunction

  // Banked register write steering
  always_comb begin
    logic [IDX_WD-1:0] idx;
    logic [IDX_WD-1:0] pidx;
    idx = wr_sel[IDX_WD-1:0];
    pidx = partner_of(idx);
    bank_we_lo = '0;
    bank_we_hi = '0;
    bank_wd = '0;
    if (wr_en && wr_sel <= regfile_pkg::sel_frame_base) begin
      unique case (wr_size)
        regfile_pkg::size_low_byte: begin
          if (byteable(wr_sel)) begin
            bank_we_lo[idx] = 1'b1;
            bank_wd[idx][BW-1:0] = wr_data[BW-1:0];
          end
        end
        regfile_pkg::size_high_byte: begin
          if (byteable(wr_sel)) begin
            bank_we_hi[idx] = 1'b1;
            bank_wd[idx][DW-1:BW] = wr_data[BW-1:0];
          end
        end
        regfile_pkg::size_word: begin
          bank_we_lo[idx] = 1'b1;
          bank_we_hi[idx] = 1'b1;
          bank_wd[idx] = wr_data[DW-1:0];
        end
        regfile_pkg::size_pair: begin
          if (pairable(wr_sel)) begin
            bank_we_lo[idx] = 1'b1;
            bank_we_hi[idx] = 1'b1;
            bank_we_lo[pidx] = 1'b1;
            bank_we_hi[pidx] = 1'b1;
            bank_wd[idx] = wr_data[DW-1:0];
            bank_wd[pidx] = wr_data[WW-1:DW];
          end
        end
      endcase
    end
  end

  genvar b;
  generate
    for (b = 0; b < regfile_pkg::BANKS; b++) begin : g_bank
      logic hit;
      assign hit = (bank_sel == 1'(b));
      regfile_bank #(
        .REGS(NB),
        .W(DW)
      ) u_bank (
        .clock(clock),
        .sys_rst(sys_rst),
        .we_lo(bank_we_lo & {NB{hit}}),
        .we_hi(bank_we_hi & {NB{hit}}),
        .wdata(bank_wd),
        .q(bank_q[b])
      );
    end
  endgenerate

  logic wr_word;
  assign wr_word = wr_en && (wr_size == regfile_pkg::size_word);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      static_base_q <= regfile_pkg::WORD_RESET;
    end else if (wr_word && wr_sel == regfile_pkg::sel_static_base) begin
      static_base_q <= wr_data[DW-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      user_stack_pointer_q <= regfile_pkg::WORD_RESET;
      interrupt_stack_pointer_q <= regfile_pkg::WORD_RESET;
    end else if (wr_word) begin
      if (wr_sel == regfile_pkg::sel_user_stack ||
          (wr_sel == regfile_pkg::sel_active_stack && stack_sel)) begin
        user_stack_pointer_q <= wr_data[DW-1:0];
      end
      if (wr_sel == regfile_pkg::sel_interrupt_stack ||
          (wr_sel == regfile_pkg::sel_active_stack && !stack_sel)) begin
        interrupt_stack_pointer_q <= wr_data[DW-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vector_table_base_q <= regfile_pkg::VEC_RESET;
    end else if (wr_word && wr_sel == regfile_pkg::sel_vector_table) begin
      vector_table_base_q <= wr_data[VW-1:0];
    end
  end

  // Program counter is loaded only by the execution unit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      program_counter_q <= regfile_pkg::PC_RESET;
    end else if (pc_load) begin
      program_counter_q <= pc_value;
    end
  end

  // Result seen at the width of the operation
  logic alu_zero;
  logic alu_sign;
  always_comb begin
    unique case (alu.size)
      regfile_pkg::size_low_byte, regfile_pkg::size_high_byte: begin
        alu_zero = (alu.result[BW-1:0] == '0);
        alu_sign = alu.result[BW-1];
      end
      regfile_pkg::size_word: begin
        alu_zero = (alu.result[DW-1:0] == '0);
        alu_sign = alu.result[DW-1];
      end
      regfile_pkg::size_pair: begin
        alu_zero = (alu.result == '0);
        alu_sign = alu.result[WW-1];
      end
    endcase
  end

  logic swi_stack;
  assign swi_stack = swi_exec && (swi_num <= regfile_pkg::SWI_STACK_MAX);

  // Writes first, ALU updates next, interrupt events last
  logic [regfile_pkg::FLAG_W-1:0] processor_flags_d;
  always_comb begin
    processor_flags_d = processor_flags_q;
    if (wr_word && wr_sel == regfile_pkg::sel_flags) begin
      processor_flags_d = wr_data[regfile_pkg::FLAG_W-1:0];
    end
    if (alu.en) begin
      processor_flags_d[regfile_pkg::FLAG_CARRY] = alu.carry;
      processor_flags_d[regfile_pkg::FLAG_ZERO] = alu_zero;
      processor_flags_d[regfile_pkg::FLAG_SIGN] = alu_sign;
      processor_flags_d[regfile_pkg::FLAG_OVERFLOW] =
        alu.overflow;
    end
    if (int_ack) begin
      processor_flags_d[regfile_pkg::FLAG_IRQ_ENABLE] = 1'b0;
      processor_flags_d[regfile_pkg::FLAG_STACK_SEL] = 1'b0;
    end
    if (swi_stack) begin
      processor_flags_d[regfile_pkg::FLAG_STACK_SEL] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      processor_flags_q <= regfile_pkg::FLAGS_RESET;
    end else begin
      processor_flags_q <= processor_flags_d;
    end
  end

  localparam int IPL_WD = regfile_pkg::IPL_W;
  logic [IPL_WD-1:0] processor_priority_level;
  assign processor_priority_level = processor_flags_q[regfile_pkg::IPL_LSB +: IPL_WD];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_take_q <= 1'b0;
    end else begin
      irq_take_q <= irq.req && !int_ack &&
                    processor_flags_q[regfile_pkg::FLAG_IRQ_ENABLE] &&
                    (irq.level > processor_priority_level);
    end
  end

  // Read path shared by both ports
  function automatic logic [WW-1:0] read_reg(
    input bank_t cur,
    input regfile_pkg::reg_sel_t s,
    input regfile_pkg::access_size_t sz,
    input logic [DW-1:0] sbase,
    input logic [DW-1:0] user_stack_pointer,
    input logic [DW-1:0] interrupt_stack_pointer,
    input logic [VW-1:0] vtb,
    input logic [VW-1:0] pc,
    input logic [regfile_pkg::FLAG_W-1:0] processor_flags);
    logic [WW-1:0] v;
    logic [IDX_WD-1:0] idx;
    idx = s[IDX_WD-1:0];
    v = '0;
    if (s <= regfile_pkg::sel_frame_base) begin
      v[DW-1:0] = cur[idx];
    end else if (s == regfile_pkg::sel_static_base) begin
      v[DW-1:0] = sbase;
    end else if (s == regfile_pkg::sel_user_stack) begin
      v[DW-1:0] = user_stack_pointer;
    end else if (s == regfile_pkg::sel_interrupt_stack) begin
      v[DW-1:0] = interrupt_stack_pointer;
    end else if (s == regfile_pkg::sel_vector_table) begin
      v[VW-1:0] = vtb;
    end else if (s == regfile_pkg::sel_program_counter) begin
      v[VW-1:0] = pc;
    end else if (s == regfile_pkg::sel_flags) begin
      v[regfile_pkg::FLAG_W-1:0] = processor_flags;
    end else if (s == regfile_pkg::sel_active_stack) begin
      v[DW-1:0] = processor_flags[regfile_pkg::FLAG_STACK_SEL] ? user_stack_pointer : interrupt_stack_pointer;
    end
    unique case (sz)
      regfile_pkg::size_low_byte: begin
        read_reg = {{(WW-BW){1'b0}}, v[BW-1:0]};
      end
      regfile_pkg::size_high_byte: begin
        read_reg = {{(WW-BW){1'b0}}, v[DW-1:BW]};
      end
      regfile_pkg::size_word: begin
        read_reg = v;
      end
      regfile_pkg::size_pair: begin
        read_reg = pairable(s) ? {cur[partner_of(idx)], cur[idx]} : v;
      end
    endcase
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      exec_rdata_q <= '0;
    end else begin
      exec_rdata_q <= read_reg(bank_q[bank_sel], exec_rsel, exec_rsize,
                               static_base_q, user_stack_pointer_q,
                               interrupt_stack_pointer_q,
                               vector_table_base_q, program_counter_q,
                               processor_flags_q);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sw_rdata_q <= '0;
    end else if (sw_rd && sw_hit) begin
      sw_rdata_q <= read_reg(bank_q[bank_sel], sw_sel,
                             regfile_pkg::size_word, static_base_q,
                             user_stack_pointer_q,
                             interrupt_stack_pointer_q,
                             vector_table_base_q, program_counter_q,
                             processor_flags_q);
    end else begin
      sw_rdata_q <= '0;
    end
  end

  // Checks
  sequence s_alu_update;
    alu.en && !(wr_word && wr_sel == regfile_pkg::sel_flags);
  endsequence

  sequence s_flags_read;
    sw_rd && sw_hit && sw_sel == regfile_pkg::sel_flags;
  endsequence

  AST_CARRY: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_alu_update |=> processor_flags_q[regfile_pkg::FLAG_CARRY] ==
                     $past(alu.carry))
    else $error("carry flag did not follow the alu");

  AST_ZERO: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_alu_update |=> processor_flags_q[regfile_pkg::FLAG_ZERO] ==
                     $past(alu_zero))
    else $error("zero flag wrong");

  AST_SIGN: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_alu_update |=> processor_flags_q[regfile_pkg::FLAG_SIGN] ==
                     $past(alu_sign))
    else $error("sign flag wrong");

  AST_OVERFLOW: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_alu_update |=> processor_flags_q[regfile_pkg::FLAG_OVERFLOW] ==
                     $past(alu.overflow))
    else $error("overflow flag wrong");

  AST_ACK_CLEARS: assert property (
    @(posedge clock) disable iff (sys_rst)
    int_ack |=> !processor_flags_q[regfile_pkg::FLAG_IRQ_ENABLE] &&
                !processor_flags_q[regfile_pkg::FLAG_STACK_SEL])
    else $error("acknowledge did not clear enable and stack flags");

  AST_SWI_STACK: assert property (
    @(posedge clock) disable iff (sys_rst)
    swi_stack |=> !processor_flags_q[regfile_pkg::FLAG_STACK_SEL])
    else $error("software interrupt did not select interrupt stack");

  AST_IRQ_GATE: assert property (
    @(posedge clock) disable iff (sys_rst)
    irq_take_q |-> $past(processor_flags_q[regfile_pkg::FLAG_IRQ_ENABLE])
                   && $past(irq.req))
    else $error("interrupt taken while disabled");

  AST_IRQ_LEVEL: assert property (
    @(posedge clock) disable iff (sys_rst)
    irq_take_q |-> $past(irq.level) > $past(processor_priority_level))
    else $error("interrupt taken at or below priority level");

  AST_PC_LOAD: assert property (
    @(posedge clock) disable iff (sys_rst)
    pc_load |=> program_counter_q == $past(pc_value))
    else $error("program counter not loaded");

  AST_FLAGS_READ: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_flags_read |=> sw_rdata_q ==
      {{(WW-regfile_pkg::FLAG_W){1'b0}}, $past(processor_flags_q)})
    else $error("flag read data wrong");

  AST_BANK_STEER: assert property (
    @(posedge clock) disable iff (sys_rst)
    (wr_word && wr_sel == regfile_pkg::sel_frame_base) |=>
      bank_q[$past(bank_sel)][regfile_pkg::sel_frame_base] ==
      $past(wr_data[DW-1:0]) && $stable(bank_q[!$past(bank_sel)]))
    else $error("write reached the wrong bank");

endmodule

// File: sim/exec_partner.sv
`timescale 1ns/1ps
module exec_partner (
  input wire logic clock,
  output regfile_pkg::exec_write_t exec_wr,
  output regfile_pkg::reg_sel_t exec_rsel,
  output regfile_pkg::access_size_t exec_rsize,
  output regfile_pkg::alu_flags_t alu,
  output logic pc_load,
  output logic [19:0] pc_value,
  output regfile_pkg::irq_req_t irq,
  output logic int_ack,
  output logic swi_exec,
  output logic [5:0] swi_num
);
  initial begin
    exec_wr = '0;
    exec_rsel = regfile_pkg::sel_data_0;
    exec_rsize = regfile_pkg::size_word;
    alu = '0;
    pc_load = 1'b0;
    pc_value = 20'h00000;
    irq = '0;
    int_ack = 1'b0;
    swi_exec = 1'b0;
    swi_num = 6'h00;
  end

  task automatic wr(input regfile_pkg::reg_sel_t s,
                    input regfile_pkg::access_size_t z,
                    input logic [31:0] d);
    @(posedge clock);
    exec_wr <= '{1'b1, s, z, d};
    @(posedge clock);
    exec_wr <= '0;
  endtask

  // Select stays applied until the next read; data settled on return
  task automatic rd(input regfile_pkg::reg_sel_t s,
                    input regfile_pkg::access_size_t z);
    @(posedge clock);
    exec_rsel <= s;
    exec_rsize <= z;
    @(posedge clock);
    #1;
  endtask

  task automatic op(input regfile_pkg::access_size_t z,
                    input logic [31:0] r, input logic c, input logic o);
    @(posedge clock);
    alu <= '{1'b1, z, r, c, o};
    @(posedge clock);
    alu <= '0;
  endtask

  task automatic load_pc(input logic [19:0] v);
    @(posedge clock);
    pc_load <= 1'b1;
    pc_value <= v;
    @(posedge clock);
    pc_load <= 1'b0;
    pc_value <= ~v;
  endtask

  task automatic ack();
    @(posedge clock);
    int_ack <= 1'b1;
    @(posedge clock);
    int_ack <= 1'b0;
  endtask

  task automatic swi(input logic [5:0] n);
    @(posedge clock);
    swi_exec <= 1'b1;
    swi_num <= n;
    @(posedge clock);
    swi_exec <= 1'b0;
    swi_num <= ~n;
  endtask

  task automatic raise(input logic r, input logic [2:0] l);
    @(posedge clock);
    irq <= '{r, l};
    @(posedge clock);
    #1;
  endtask
endmodule

// File: sim/cpu_register_file_flags_tb.sv
`timescale 1ns/1ps
module cpu_register_file_flags_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] sw_addr = 6'h00;
  logic [31:0] sw_wdata = 32'h00000000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata_q;
  logic [31:0] exec_rdata_q;
  logic irq_take_q;
  logic [19:0] program_counter_q;
  logic [10:0] processor_flags_q;
  regfile_pkg::exec_write_t exec_wr;
  regfile_pkg::reg_sel_t exec_rsel;
  regfile_pkg::access_size_t exec_rsize;
  regfile_pkg::alu_flags_t alu;
  logic pc_load;
  logic [19:0] pc_value;
  regfile_pkg::irq_req_t irq;
  logic int_ack;
  logic swi_exec;
  logic [5:0] swi_num;
  int fail_count = 0;
  int comparisons = 0;

  always #2.5 clock = ~clock;

  exec_partner xu (.clock(clock), .exec_wr(exec_wr), .exec_rsel(exec_rsel),
    .exec_rsize(exec_rsize), .alu(alu), .pc_load(pc_load),
    .pc_value(pc_value), .irq(irq), .int_ack(int_ack),
    .swi_exec(swi_exec), .swi_num(swi_num));

  cpu_register_file_flags DUT (.clock(clock), .sys_rst(sys_rst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata_q(sw_rdata_q), .exec_wr(exec_wr), .exec_rsel(exec_rsel),
    .exec_rsize(exec_rsize), .exec_rdata_q(exec_rdata_q), .alu(alu),
    .pc_load(pc_load), .pc_value(pc_value), .irq(irq), .int_ack(int_ack),
    .swi_exec(swi_exec), .swi_num(swi_num), .irq_take_q(irq_take_q),
    .program_counter_q(program_counter_q),
    .processor_flags_q(processor_flags_q));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sw_write(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_read(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clock);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1;
    check(sw_rdata_q, exp);
  endtask

  task automatic close_out();
    $display("errors=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #25000;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    sw_read(6'h30, 32'h0); // Flags clear after reset
    sw_read(6'h2c, 32'h0);
    for (int i = 0; i < 11; i++) begin
      sw_write(6'(i * 4), 32'h9e3779b0 + i);
    end
    for (int i = 0; i < 11; i++) begin
      sw_read(6'(i * 4), (32'h9e3779b0 + i) &
        ((i == 10) ? 32'h000fffff : 32'h0000ffff));
    end
    sw_read(6'h34, 32'h0); // Past the flags reads zero
    sw_read(6'h01, 32'h0); // Misaligned reads zero
    sw_write(6'h2c, 32'h12345); // Software cannot load it
    sw_read(6'h2c, 32'h0);
    xu.load_pc(20'habcde);
    sw_read(6'h2c, 32'habcde);
    check({12'h000, program_counter_q}, 32'habcde);
    xu.wr(regfile_pkg::sel_data_1, regfile_pkg::size_high_byte,
      32'hab);
    sw_read(6'h04, 32'habb1);
    xu.rd(regfile_pkg::sel_data_1, regfile_pkg::size_high_byte);
    check(exec_rdata_q, 32'hab);
    xu.rd(regfile_pkg::sel_data_1, regfile_pkg::size_low_byte);
    check(exec_rdata_q, 32'hb1);
    xu.wr(regfile_pkg::sel_data_0, regfile_pkg::size_pair,
      32'h12345678);
    sw_read(6'h00, 32'h5678);
    sw_read(6'h08, 32'h1234);
    xu.wr(regfile_pkg::sel_address_0, regfile_pkg::size_pair,
      32'hcafe0123);
    sw_read(6'h14, 32'hcafe);
    xu.rd(regfile_pkg::sel_address_0, regfile_pkg::size_pair);
    check(exec_rdata_q, 32'hcafe0123);
    xu.rd(regfile_pkg::sel_active_stack, regfile_pkg::size_word);
    check(exec_rdata_q, 32'h79b9);
    sw_write(6'h30, 32'h080); // Stack select flag set, debug flag kept low
    xu.rd(regfile_pkg::sel_active_stack, regfile_pkg::size_word);
    check(exec_rdata_q, 32'h79b8);
    sw_write(6'h30, 32'h010);
    sw_write(6'h00, 32'h1111);
    sw_read(6'h00, 32'h1111);
    xu.rd(regfile_pkg::sel_data_0, regfile_pkg::size_word);
    check(exec_rdata_q, 32'h1111);
    sw_write(6'h30, 32'h000);
    sw_read(6'h00, 32'h5678);
    xu.op(regfile_pkg::size_word, 32'h0, 1'b1, 1'b0);
    sw_read(6'h30, 32'h005);
    xu.op(regfile_pkg::size_low_byte, 32'h180, 1'b0, 1'b1);
    sw_read(6'h30, 32'h028);
    xu.op(regfile_pkg::size_pair, 32'h80000000, 1'b0, 1'b0);
    sw_read(6'h30, 32'h008);
    xu.op(regfile_pkg::size_word, 32'h80000000, 1'b0, 1'b0);
    sw_read(6'h30, 32'h004);
    sw_write(6'h30, 32'h2c0);
    xu.raise(1'b1, 3'h3);
    check(irq_take_q, 32'h1);
    xu.raise(1'b1, 3'h2);
    check(irq_take_q, 32'h0);
    xu.ack();
    sw_read(6'h30, 32'h200);
    check({21'h0, processor_flags_q}, 32'h200);
    xu.raise(1'b1, 3'h7);
    check(irq_take_q, 32'h0);
    xu.raise(1'b0, 3'h0);
    sw_write(6'h30, 32'h080);
    xu.swi(6'h20);
    sw_read(6'h30, 32'h080);
    xu.swi(6'h1f);
    sw_read(6'h30, 32'h000);
    @(posedge clock);
    sys_rst <= 1'b1; // Mid-run reset
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    sw_read(6'h00, 32'h0);
    sw_read(6'h28, 32'h0);
    check({12'h000, program_counter_q}, 32'h0);
    close_out();
  end
endmodule
